/* File: hw/tugc_global_control.sv */
// Global control register zero and the transaction decisions it steers.
`timescale 1ns/1ps
`default_nettype none
module tugc_global_control
  import tugc_pkg::*;
#(
  parameter bit WIDE_VM_IDENT_SUP = 1'b1,
  parameter bit HYP_EXT_SUP = 1'b1,
  parameter bit ALLOC_SUP = 1'b1,
  parameter bit SHARE_SUP = 1'b1,
  parameter bit BCAST_SUP = 1'b1,
  parameter bit PRIV_MAINT_SUP = 1'b1,
  parameter bit GSTALL_SUP = 1'b1,
  parameter bit BSU_SUP = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic txn_valid,
  input wire logic txn_global_fault,
  input wire logic txn_no_match,
  input wire logic txn_multi_match,
  input wire logic txn_exclusive,
  output tugc_cfg_t cfg_out,
  output tugc_resp_t resp_out,
  output logic resp_valid
);

  // ---------------------------------------------------------------
  // Elaboration checks.
  // ---------------------------------------------------------------
  // A private maintenance opt-out only means something with broadcast support.
  if (PRIV_MAINT_SUP && !BCAST_SUP) begin : g_bad_cfg
    $error("Private maintenance support needs broadcast support.");
  end

  // ---------------------------------------------------------------
  // Register storage.
  // ---------------------------------------------------------------
  logic [31:0] cfg_q;
  logic [31:0] cfg_d;
  logic [31:0] view;
  logic hit;

  assign hit = (reg_addr == TUGC_OFS_CFG0);

  // Write filter: read-only and unsupported fields keep their fixed value.
  always_comb begin
    cfg_d = reg_wdata;
    cfg_d[29:28] = 2'h0;
    if (!WIDE_VM_IDENT_SUP) cfg_d[TUGC_B_WIDE_VM_IDENT] = 1'b0;
    if (!HYP_EXT_SUP) cfg_d[TUGC_B_HYP_SEL] = 1'b0;
    if (!ALLOC_SUP) begin
      cfg_d[TUGC_B_WALLOC +: 2] = 2'h0;
      cfg_d[TUGC_B_RALLOC +: 2] = 2'h0;
    end
    if (!SHARE_SUP) cfg_d[TUGC_B_SHARE +: 2] = 2'h0;
    if (!BSU_SUP) cfg_d[TUGC_B_BSU +: 2] = 2'h0;
    if (!BCAST_SUP) cfg_d[TUGC_B_PTM] = 1'b1;
    else if (!PRIV_MAINT_SUP) cfg_d[TUGC_B_PTM] = 1'b0;
    // Stall disable wins over a global stall enable in the same write.
    if (!GSTALL_SUP || reg_wdata[TUGC_B_STALL_DISABLE]) cfg_d[TUGC_B_GSE] = 1'b0;
    cfg_d[7:3] = 5'h00;
  end

  // Register update; the undefined-reset fields are given zero for determinism.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_q <= TUGC_RESET_CFG0;
      if (!BCAST_SUP) cfg_q[TUGC_B_PTM] <= 1'b1;
    end else if (clk_en && reg_wr && hit) begin
      cfg_q <= cfg_d;
    end
  end

  // Read view also masks global stall while stall disable is set.
  always_comb begin
    view = cfg_q;
    if (cfg_q[TUGC_B_STALL_DISABLE]) view[TUGC_B_GSE] = 1'b0;
  end

  // Read data stands one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      reg_rdata <= (reg_rd && hit) ? view : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Configuration outputs.
  // ---------------------------------------------------------------
  // Registered copy so every output comes from a flip-flop. The hypervisor
  // context meaning changes here at once; flushing stale translations is
  // left to software.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_out <= '0;
    end else if (clk_en) begin
      cfg_out.wide_vm_ident_en <= view[TUGC_B_WIDE_VM_IDENT];
      cfg_out.hyp_context_select <= view[TUGC_B_HYP_SEL];
      cfg_out.write_alloc_override <= view[TUGC_B_WALLOC +: 2];
      cfg_out.read_alloc_override <= view[TUGC_B_RALLOC +: 2];
      cfg_out.share_override <= view[TUGC_B_SHARE +: 2];
      cfg_out.multi_match_fault_cfg <= view[TUGC_B_MULTI];
      cfg_out.mem_type_override_en <= view[TUGC_B_MTYPE_EN];
      // Attributes only reach the bypass path when the override is on.
      cfg_out.bypass_mem_attrs <= view[TUGC_B_MTYPE_EN] ?
                                  view[TUGC_B_MATTR +: 4] : 4'h0;
      cfg_out.barrier_share_upgrade <= view[TUGC_B_BSU +: 2];
      cfg_out.force_maint_broadcast <= view[TUGC_B_FBCAST];
      cfg_out.private_tlb_maint <= view[TUGC_B_PTM];
      cfg_out.private_vm_namespace <= view[TUGC_B_PNS];
      cfg_out.unmatched_stream_fault_cfg <= view[TUGC_B_USF];
      cfg_out.global_stall_en <= view[TUGC_B_GSE];
      cfg_out.stall_disable <= view[TUGC_B_STALL_DISABLE];
    end
  end

  // ---------------------------------------------------------------
  // Transaction decisions.
  // ---------------------------------------------------------------
  logic flt;
  logic pass;

  // A fault is a global fault, a flagged multi-match or a flagged unmatched stream.
  always_comb begin
    flt = txn_global_fault
        | (txn_multi_match & view[TUGC_B_MULTI])
        | (txn_no_match & view[TUGC_B_USF]);
    pass = view[TUGC_B_BYPASS]
         | (txn_multi_match & ~view[TUGC_B_MULTI])
         | (txn_no_match & ~txn_multi_match & ~view[TUGC_B_USF]);
  end

  // One decision per request, one cycle later.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      resp_out <= '0;
      resp_valid <= 1'b0;
    end else if (clk_en) begin
      resp_valid <= txn_valid;
      resp_out.bypass <= txn_valid & pass & ~(flt & ~view[TUGC_B_BYPASS]);
      resp_out.fault <= txn_valid & flt & ~view[TUGC_B_BYPASS];
      resp_out.irq <= txn_valid & flt & ~view[TUGC_B_BYPASS] & view[TUGC_B_IRQ_EN];
      resp_out.abort <= txn_valid & flt & ~view[TUGC_B_BYPASS] & view[TUGC_B_ABORT_EN];
      resp_out.excl_fail <= txn_valid & flt & ~view[TUGC_B_BYPASS] &
                            ~view[TUGC_B_ABORT_EN] & txn_exclusive;
    end
  end

endmodule // tugc_global_control
`default_nettype wire

/* File: hw/tugc_pkg.sv */
// Package with the field layout, reset values and encodings of the global control register.
package tugc_pkg;

  // ---------------------------------------------------------------
  // Register map.
  // ---------------------------------------------------------------
  localparam logic [7:0] TUGC_OFS_CFG0 = 8'h00;
  localparam logic [31:0] TUGC_RESET_CFG0 = 32'h0000_0001;

  // ---------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------
  localparam int TUGC_B_WIDE_VM_IDENT = 31;
  localparam int TUGC_B_HYP_SEL = 30;
  localparam int TUGC_B_WALLOC = 26;
  localparam int TUGC_B_RALLOC = 24;
  localparam int TUGC_B_SHARE = 22;
  localparam int TUGC_B_MULTI = 21;
  localparam int TUGC_B_MTYPE_EN = 20;
  localparam int TUGC_B_MATTR = 16;
  localparam int TUGC_B_BSU = 14;
  localparam int TUGC_B_FBCAST = 13;
  localparam int TUGC_B_PTM = 12;
  localparam int TUGC_B_PNS = 11;
  localparam int TUGC_B_USF = 10;
  localparam int TUGC_B_GSE = 9;
  localparam int TUGC_B_STALL_DISABLE = 8;
  localparam int TUGC_B_IRQ_EN = 2;
  localparam int TUGC_B_ABORT_EN = 1;
  localparam int TUGC_B_BYPASS = 0;

  // ---------------------------------------------------------------
  // Encodings.
  // ---------------------------------------------------------------
  localparam logic [1:0] TUGC_ALLOC_RSVD = 2'h1;
  localparam logic [1:0] TUGC_ALLOC_YES = 2'h2;
  localparam logic [1:0] TUGC_ALLOC_NO = 2'h3;

  // Configuration presented to the transaction path.
  typedef struct packed {
    logic wide_vm_ident_en;
    logic hyp_context_select;
    logic [1:0] write_alloc_override;
    logic [1:0] read_alloc_override;
    logic [1:0] share_override;
    logic multi_match_fault_cfg;
    logic mem_type_override_en;
    logic [3:0] bypass_mem_attrs;
    logic [1:0] barrier_share_upgrade;
    logic force_maint_broadcast;
    logic private_tlb_maint;
    logic private_vm_namespace;
    logic unmatched_stream_fault_cfg;
    logic global_stall_en;
    logic stall_disable;
  } tugc_cfg_t;

  // Per-transaction decisions.
  typedef struct packed {
    logic bypass;
    logic fault;
    logic abort;
    logic excl_fail;
    logic irq;
  } tugc_resp_t;

endpackage

/* File: verification/tugc_global_control_sva.sv */
// Assertions on the global control register and its transaction answers.
`timescale 1ns/1ps
`default_nettype none
module tugc_global_control_sva
  import tugc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic txn_valid,
  input wire logic txn_global_fault,
  input wire logic txn_no_match,
  input wire logic txn_multi_match,
  input wire logic txn_exclusive,
  input wire tugc_cfg_t cfg_out,
  input wire tugc_resp_t resp_out,
  input wire logic resp_valid
);
  // Last word written and a copy one cycle older, so no assertion needs a deep $past.
  logic [31:0] w_q, p_q;
  always_ff @(posedge clk_sys) begin
    p_q <= rst ? TUGC_RESET_CFG0 : w_q;
    if (rst)
      w_q <= TUGC_RESET_CFG0;
    else if (clk_en && reg_wr && reg_addr == TUGC_OFS_CFG0)
      w_q <= reg_wdata;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence txn_s; clk_en && txn_valid; endsequence
  sequence rd_s; clk_en && reg_rd && reg_addr == TUGC_OFS_CFG0; endsequence
  fault_src_a:
    assert property (txn_s |=> resp_valid && resp_out.fault == (!p_q[0] && ($past(txn_global_fault)
      || $past(txn_multi_match) && p_q[21] || $past(txn_no_match) && p_q[10])))
      else $error("fault cause wrong");
  irq_gate_a: assert property (txn_s |=> resp_out.irq == (resp_out.fault && p_q[2]))
    else $error("irq gating wrong");
  abort_gate_a: assert property (txn_s |=> resp_out.abort == (resp_out.fault && p_q[1]))
    else $error("abort gating wrong");
  excl_fail_a:
    assert property (txn_s |=> resp_out.excl_fail == (resp_out.fault && !p_q[1] && $past(txn_exclusive)))
      else $error("exclusive report wrong");
  bypass_a: assert property (txn_s ##1 p_q[0] |-> resp_out.bypass && !resp_out.fault)
    else $error("bypass wrong");
  quiet_a: assert property (clk_en && !txn_valid |=> !resp_valid)
    else $error("answer without request");
  readback_a: assert property (rd_s |=> (reg_rdata & 32'hCFFF_FD07) == (p_q & 32'hCFFF_FD07))
    else $error("read data wrong");
  stall_off_a: assert property (rd_s |=> reg_rdata[9] == (p_q[9] && !p_q[8]))
    else $error("stall enable wrong");
  rd_idle_a:
    assert property (!(clk_en && reg_rd && reg_addr == TUGC_OFS_CFG0) |=> reg_rdata == 32'h0000_0000)
      else $error("read data not idle");
  cfg_lag_a:
    assert property (cfg_out.write_alloc_override == p_q[27:26]
      && cfg_out.bypass_mem_attrs == (p_q[20] ? p_q[19:16] : 4'h0)) else $error("cfg copy wrong");
endmodule // tugc_global_control_sva
bind tugc_global_control tugc_global_control_sva i_tugc_global_control_sva (.*);
`default_nettype wire

/* File: verification/tugc_client_model.sv */
// Behavioural client master issuing one transaction per request.
`timescale 1ns/1ps
`default_nettype none
module tugc_client_model (
  input wire logic clk_sys,
  input wire logic go,
  input wire logic [3:0] kind,
  output logic txn_valid,
  output logic [3:0] flags
);
  initial begin
    txn_valid = 1'b0;
    flags = 4'h0;
  end
  // Idle flags show the inverse of the last value, so a stale level never passes.
  always @(posedge clk_sys) begin
    txn_valid <= go;
    flags <= go ? kind : ~flags;
  end
endmodule // tugc_client_model
`default_nettype wire

/* File: verification/test_tugc_global_control.sv */
// Self-checking bench for the global control register block.
`timescale 1ns/1ps
`default_nettype none
module test_tugc_global_control
  import tugc_pkg::*;
;
  logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, go = 0, txn_valid, resp_valid;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
  logic [3:0] kind = 4'h0, flags;
  logic [1:0] c2, a2;
  tugc_cfg_t cfg_out;
  tugc_resp_t resp_out;
  int n_mismatch = 0, total_checks = 0;
  initial forever #5 clk_sys = ~clk_sys;
  tugc_global_control i_tugc_global_control (.clk_sys, .rst, .clk_en(1'b1), .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .txn_valid, .txn_global_fault(flags[3]),
    .txn_no_match(flags[2]), .txn_multi_match(flags[1]), .txn_exclusive(flags[0]),
    .cfg_out, .resp_out, .resp_valid);
  tugc_client_model i_tugc_client_model (.clk_sys, .go, .kind, .txn_valid, .flags);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read data live only in the cycle after the strobe, so they are sampled just past that edge.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check("reg_rdata", reg_rdata, e);
  endtask
  // Program the register, issue one transaction and compare the answer a cycle after it.
  task automatic tx(input logic [31:0] r, input logic [3:0] k, input logic [4:0] e);
    wr(8'h00, r);
    @(posedge clk_sys);
    go <= 1'b1;
    kind <= k;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    #1 check("resp_out", 32'({resp_valid, resp_out}), 32'({1'b1, e}));
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rd(8'h00, 32'h0000_0001);
    // The bench has no translations cached, so flipping the hypervisor bit needs no flush here.
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00, 32'hCFFF_FD07);
    check("cfg_out", 32'(cfg_out), 32'h003F_FFFD);
    wr(8'h00, 32'h0000_0200);
    rd(8'h00, 32'h0000_0200);
    wr(8'h04, 32'hFFFF_FFFF);
    rd(8'h00, 32'h0000_0200);
    rd(8'h04, 32'h0000_0000);
    // Allocation codes never take the reserved value, shareability and barrier codes take all.
    for (int c = 0; c < 4; c++) begin
      c2 = 2'(c);
      a2 = {c2[1] | c2[0], c2[1]};
      wr(8'h00, {4'h0, a2, a2, c2, 2'b01, 2'b00, c2, c2, 14'h0000});
      rd(8'h00, {4'h0, a2, a2, c2, 2'b01, 2'b00, c2, c2, 14'h0000});
      check("cfg_out", 32'(cfg_out), 32'({2'b00, a2, a2, c2, 2'b01, 2'b00, c2, c2, 6'h00}));
    end
    tx(32'h0000_0001, 4'h8, 5'b10000);
    tx(32'h0000_0006, 4'h8, 5'b01101);
    tx(32'h0000_0000, 4'h9, 5'b01010);
    tx(32'h0020_0000, 4'h2, 5'b01000);
    tx(32'h0000_0404, 4'h4, 5'b01001);
    complete_run();
  end
  // Limit far beyond the 65 or so cycles the sequence needs.
  initial begin
    #50000;
    n_mismatch++;
    complete_run();
  end
endmodule // test_tugc_global_control
`default_nettype wire
